// >>> design/dtsi_top.sv
// dual trunk card status, indicator and d-channel handshake logic with ahb-lite registers
`timescale 1ns/1ps

module dtsi_top #(
  parameter bit EXT_VARIANT = 1'b1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic card_enable_switch,
  input wire logic handler_ready_flag,
  input wire dtsi_pkg::dtsi_line_in_type line_in,
  output logic link_operational_flag,
  output dtsi_pkg::dtsi_ind_type ind,
  output dtsi_pkg::dtsi_refclk_type ref_clk,
  output dtsi_pkg::dtsi_loop_type loop_cfg,
  output logic irq
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [dtsi_pkg::DTSI_CTRL_W-1:0] ctrl;
    dtsi_pkg::dtsi_loop_type loop;
    logic [dtsi_pkg::DTSI_INT_W-1:0] int_stat;
    logic [dtsi_pkg::DTSI_INT_W-1:0] int_mask;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic hready;
    logic link_op;
    logic ready;
    dtsi_pkg::dtsi_ind_type ind;
    dtsi_pkg::dtsi_refclk_type refclk;
    logic irq;
  } dtsi_state_type;

  localparam dtsi_state_type STATE_RST = '{
    ctrl: dtsi_pkg::DTSI_CTRL_RST,
    loop: dtsi_pkg::DTSI_LOOP_RST,
    ind: dtsi_pkg::DTSI_IND_RST,
    hready: 1'b1,
    default: '0
  };

  dtsi_state_type st_q;
  dtsi_state_type st_d;

  logic bus_live;
  logic accept;
  logic [1:0] near_now;
  logic [1:0] far_now;
  logic [1:0] sw_off;
  logic [dtsi_pkg::DTSI_INT_W-1:0] int_set;
  logic [dtsi_pkg::DTSI_INT_W-1:0] int_clr;
  logic cfg_rej;
  logic link_port;
  logic card_up;
  dtsi_pkg::dtsi_mode_type link_mode;
  dtsi_pkg::dtsi_loop_type new_loop;
  logic [31:0] rd_mux;

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    int_clr = '0;
    cfg_rej = 1'b0;
    new_loop = dtsi_pkg::dtsi_loop_type'(hwdata[5:0]);

    // a card switched to disable neither takes nor answers processor accesses
    bus_live = card_enable_switch;
    accept = bus_live && hsel && htrans[1] && hready;

    // data phase of a write: a pending write is dropped if the switch went to disable
    if (st_q.wr_pend && bus_live) begin
      unique case (st_q.wr_addr)
        dtsi_pkg::DTSI_ADDR_CTRL: begin
          st_d.ctrl = hwdata[dtsi_pkg::DTSI_CTRL_W-1:0];
        end
        dtsi_pkg::DTSI_ADDR_LOOP: begin
          if (dtsi_pkg::dtsi_pair_ok(new_loop.mode0, new_loop.mode1, EXT_VARIANT)) begin
            st_d.loop = new_loop;
          end else begin
            cfg_rej = 1'b1;
          end
        end
        dtsi_pkg::DTSI_ADDR_INT_STAT: begin
          int_clr = hwdata[dtsi_pkg::DTSI_INT_W-1:0];
        end
        dtsi_pkg::DTSI_ADDR_INT_MASK: begin
          st_d.int_mask = hwdata[dtsi_pkg::DTSI_INT_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // address phase
    st_d.wr_pend = accept && hwrite;
    st_d.wr_addr = haddr[7:0];

    // read data is fetched at the address phase so it stands from a flop in the data phase
    unique case (haddr[7:0])
      dtsi_pkg::DTSI_ADDR_CTRL: rd_mux = {21'h0, st_q.ctrl};
      dtsi_pkg::DTSI_ADDR_LOOP: rd_mux = {26'h0, st_q.loop};
      dtsi_pkg::DTSI_ADDR_STATUS: rd_mux = {15'h0, st_q.ready, st_q.link_op, card_enable_switch,
                                            st_q.ind.board_green, st_q.ind.board_red,
                                            st_q.ind.remote_loopback, st_q.ind.far_end_alarm,
                                            st_q.ind.near_end_alarm, st_q.ind.out_of_service,
                                            st_q.ind.trunk_disabled, st_q.ind.net_port_off};
      dtsi_pkg::DTSI_ADDR_INT_STAT: rd_mux = {24'h0, st_q.int_stat};
      dtsi_pkg::DTSI_ADDR_INT_MASK: rd_mux = {24'h0, st_q.int_mask};
      default: rd_mux = 32'h0;
    endcase
    st_d.rdata = (accept && !hwrite) ? rd_mux : 32'h0;
    st_d.hready = 1'b1;

    // line conditions
    near_now = line_in.signal_loss | line_in.sync_loss;
    far_now = line_in.remote_alarm_rx;
    st_d.ready = handler_ready_flag;

    // lamps, all registered so they change on the clock only
    card_up = card_enable_switch && st_q.ctrl[dtsi_pkg::DTSI_CTRL_CARD_EN];
    sw_off = st_q.ctrl[dtsi_pkg::DTSI_CTRL_NET_OFF +: 2];
    st_d.ind.net_port_off = {2{!card_up}} | sw_off;
    st_d.ind.trunk_disabled = st_q.ctrl[dtsi_pkg::DTSI_CTRL_TRUNK_OFF +: 2];
    st_d.ind.out_of_service = st_q.ctrl[dtsi_pkg::DTSI_CTRL_OUT_SERV +: 2];
    st_d.ind.near_end_alarm = near_now;
    st_d.ind.far_alarm_tx = near_now;
    st_d.ind.far_end_alarm = far_now;
    st_d.ind.remote_loopback = line_in.remote_loopback;
    st_d.ind.call_inhibit = line_in.remote_loopback;
    st_d.ind.board_red = st_q.ctrl[dtsi_pkg::DTSI_CTRL_BOARD_CFG] && !st_q.ctrl[dtsi_pkg::DTSI_CTRL_BOARD_EN];
    st_d.ind.board_green = st_q.ctrl[dtsi_pkg::DTSI_CTRL_BOARD_CFG] && st_q.ctrl[dtsi_pkg::DTSI_CTRL_BOARD_EN];
    // extended addressing only means something on a private signalling loop
    st_d.ind.ext_addr[0] = st_q.loop.ext_addr[0] && (st_q.loop.mode0 == dtsi_pkg::DTSI_MODE_PSIG);
    st_d.ind.ext_addr[1] = st_q.loop.ext_addr[1] && (st_q.loop.mode1 == dtsi_pkg::DTSI_MODE_PSIG);

    // recovered clocks fan out to both controllers; one flop of delay, no glitches
    st_d.refclk.to_ctl0 = line_in.rec_clk;
    st_d.refclk.to_ctl1 = line_in.rec_clk;

    // d-channel link usable toward the external handler
    link_port = st_q.ctrl[dtsi_pkg::DTSI_CTRL_LINK_PORT];
    link_mode = link_port ? st_q.loop.mode1 : st_q.loop.mode0;
    st_d.link_op = st_q.ctrl[dtsi_pkg::DTSI_CTRL_RATE64] && card_up
                && (link_mode == dtsi_pkg::DTSI_MODE_PRATE) && !st_q.ind.trunk_disabled[link_port]
                && !st_q.ind.out_of_service[link_port] && !near_now[link_port] && !far_now[link_port];

    // sticky events: a new event wins over a write-one-to-clear in the same cycle
    int_set = '0;
    int_set[dtsi_pkg::DTSI_INT_NEAR +: 2] = near_now & ~st_q.ind.near_end_alarm;
    int_set[dtsi_pkg::DTSI_INT_FAR +: 2] = far_now & ~st_q.ind.far_end_alarm;
    int_set[dtsi_pkg::DTSI_INT_LOOPBACK +: 2] = line_in.remote_loopback & ~st_q.ind.remote_loopback;
    int_set[dtsi_pkg::DTSI_INT_READY] = handler_ready_flag ^ st_q.ready;
    int_set[dtsi_pkg::DTSI_INT_CFG_REJ] = cfg_rej;
    st_d.int_stat = (st_q.int_stat & ~int_clr) | int_set;
    st_d.irq = |(st_d.int_stat & st_d.int_mask);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign hreadyout = st_q.hready;
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;
  assign link_operational_flag = st_q.link_op;
  assign ind = st_q.ind;
  assign ref_clk = st_q.refclk;
  assign loop_cfg = st_q.loop;
  assign irq = st_q.irq;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  a_link_off_rate: assert property (@(posedge clk_sys) disable iff (!resetn)
    !st_q.ctrl[dtsi_pkg::DTSI_CTRL_RATE64] |=> !link_operational_flag)
    else $error("link flag on without 64k rate");

  a_link_off_alarm: assert property (@(posedge clk_sys) disable iff (!resetn)
    (near_now[link_port] || line_in.remote_alarm_rx[link_port]) |=> !link_operational_flag)
    else $error("link flag on during alarm");

  a_link_on_cause: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st_q.ctrl[dtsi_pkg::DTSI_CTRL_RATE64] && card_enable_switch && st_q.ctrl[dtsi_pkg::DTSI_CTRL_CARD_EN]
     && !st_q.ctrl[dtsi_pkg::DTSI_CTRL_LINK_PORT] && st_q.loop.mode0 == dtsi_pkg::DTSI_MODE_PRATE
     && !st_q.ind.trunk_disabled[0] && !st_q.ind.out_of_service[0] && !near_now[0] && !far_now[0])
    |=> link_operational_flag)
    else $error("link flag off though link usable");

  a_switch_ignore: assert property (@(posedge clk_sys) disable iff (!resetn)
    !card_enable_switch |=> $stable(st_q.ctrl) && $stable(st_q.loop) && hrdata == 32'h0)
    else $error("access taken while switch at disable");

  a_net_off_lamp: assert property (@(posedge clk_sys) disable iff (!resetn)
    !card_enable_switch |=> ind.net_port_off == 2'h3)
    else $error("network loop lamp dark with switch at disable");

  a_service_lamp: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_q.ctrl[dtsi_pkg::DTSI_CTRL_OUT_SERV] |=> ind.out_of_service[0])
    else $error("out of service lamp not lit");

  a_near_alarm: assert property (@(posedge clk_sys) disable iff (!resetn)
    (line_in.signal_loss[1] || line_in.sync_loss[1]) |=> ind.near_end_alarm[1] && ind.far_alarm_tx[1])
    else $error("near-end alarm not shown or sent");

  a_near_event: assert property (@(posedge clk_sys) disable iff (!resetn)
    (near_now[1] && !ind.near_end_alarm[1]) |=> st_q.int_stat[dtsi_pkg::DTSI_INT_NEAR + 1])
    else $error("near-end alarm event not latched");

  a_far_alarm: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(line_in.remote_alarm_rx[0]) |=> ind.far_end_alarm[0]
    ##1 (ind.far_end_alarm[0] == $past(line_in.remote_alarm_rx[0])))
    else $error("far-end alarm lamp wrong");

  a_loopback: assert property (@(posedge clk_sys) disable iff (!resetn)
    line_in.remote_loopback[0] |=> ind.remote_loopback[0] && ind.call_inhibit[0])
    else $error("loopback not shown or calls not inhibited");

  a_board_lamp: assert property (@(posedge clk_sys) disable iff (!resetn)
    !st_q.ctrl[dtsi_pkg::DTSI_CTRL_BOARD_CFG] |=> !ind.board_red && !ind.board_green)
    else $error("daughterboard lamp lit without board");

  a_ref_clk: assert property (@(posedge clk_sys) disable iff (!resetn)
    ##1 (ref_clk.to_ctl0 == $past(line_in.rec_clk)) && (ref_clk.to_ctl1 == ref_clk.to_ctl0))
    else $error("recovered clock not sent to both controllers");

  a_loop_legal: assert property (@(posedge clk_sys) disable iff (!resetn)
    dtsi_pkg::dtsi_pair_ok(loop_cfg.mode0, loop_cfg.mode1, EXT_VARIANT))
    else $error("illegal loop pairing held");

  a_irq_level: assert property (@(posedge clk_sys) disable iff (!resetn)
    irq |-> |(st_q.int_stat & st_q.int_mask))
    else $error("interrupt without unmasked status");

endmodule : dtsi_top

// >>> pkg/dtsi_pkg.sv
// constants, types and helpers for the dual trunk status and indication block
package dtsi_pkg;

  // -------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------
  localparam logic [7:0] DTSI_ADDR_CTRL = 8'h00;
  localparam logic [7:0] DTSI_ADDR_LOOP = 8'h04;
  localparam logic [7:0] DTSI_ADDR_STATUS = 8'h08;
  localparam logic [7:0] DTSI_ADDR_INT_STAT = 8'h0c;
  localparam logic [7:0] DTSI_ADDR_INT_MASK = 8'h10;

  // control register fields
  localparam int DTSI_CTRL_W = 11;
  localparam int DTSI_CTRL_CARD_EN = 0;
  localparam int DTSI_CTRL_NET_OFF = 1;
  localparam int DTSI_CTRL_TRUNK_OFF = 3;
  localparam int DTSI_CTRL_OUT_SERV = 5;
  localparam int DTSI_CTRL_RATE64 = 7;
  localparam int DTSI_CTRL_BOARD_CFG = 8;
  localparam int DTSI_CTRL_BOARD_EN = 9;
  localparam int DTSI_CTRL_LINK_PORT = 10;
  // trunk ports start disabled, card starts not enabled
  localparam logic [DTSI_CTRL_W-1:0] DTSI_CTRL_RST = 11'h018;

  // interrupt status and mask fields
  localparam int DTSI_INT_W = 8;
  localparam int DTSI_INT_NEAR = 0;
  localparam int DTSI_INT_FAR = 2;
  localparam int DTSI_INT_LOOPBACK = 4;
  localparam int DTSI_INT_READY = 6;
  localparam int DTSI_INT_CFG_REJ = 7;

  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    DTSI_MODE_NONE = 2'b00,
    DTSI_MODE_DTRUNK = 2'b01,
    DTSI_MODE_PRATE = 2'b10,
    DTSI_MODE_PSIG = 2'b11
  } dtsi_mode_type;

  typedef struct packed {
    logic [1:0] ext_addr;
    dtsi_mode_type mode1;
    dtsi_mode_type mode0;
  } dtsi_loop_type;

  localparam dtsi_loop_type DTSI_LOOP_RST = '{ext_addr: 2'h0, mode1: DTSI_MODE_NONE, mode0: DTSI_MODE_NONE};

  typedef struct packed {
    logic [1:0] signal_loss;
    logic [1:0] sync_loss;
    logic [1:0] remote_alarm_rx;
    logic [1:0] remote_loopback;
    logic [1:0] rec_clk;
  } dtsi_line_in_type;

  typedef struct packed {
    logic [1:0] net_port_off;
    logic [1:0] trunk_disabled;
    logic [1:0] out_of_service;
    logic [1:0] near_end_alarm;
    logic [1:0] far_end_alarm;
    logic [1:0] remote_loopback;
    logic [1:0] far_alarm_tx;
    logic [1:0] call_inhibit;
    logic [1:0] ext_addr;
    logic board_red;
    logic board_green;
  } dtsi_ind_type;

  localparam dtsi_ind_type DTSI_IND_RST = '{net_port_off: 2'h3, trunk_disabled: 2'h3, default: '0};

  typedef struct packed {
    logic [1:0] to_ctl0;
    logic [1:0] to_ctl1;
  } dtsi_refclk_type;

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic dtsi_pair_ok(dtsi_mode_type m0, dtsi_mode_type m1, logic ext_variant);
    logic ok;
    ok = 1'b1;
    if (!ext_variant && (m0 == DTSI_MODE_PSIG || m1 == DTSI_MODE_PSIG)) begin
      ok = 1'b0;
    end
    if ((m0 == DTSI_MODE_PRATE && m1 == DTSI_MODE_PSIG) || (m0 == DTSI_MODE_PSIG && m1 == DTSI_MODE_PRATE)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : dtsi_pair_ok

endpackage : dtsi_pkg

// >>> verif/dtsi_handler_model.sv
// behavioural model of the external d-channel handler card
`timescale 1ns/1ps

module dtsi_handler_model #(
  parameter int SLOW_WAIT = 6
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic slow,
  input wire logic link_operational_flag,
  output logic handler_ready_flag
);
  int cnt_q;

  // a real handler only claims readiness once the card reports a usable link
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 0;
      handler_ready_flag <= 1'b0;
    end else if (!link_operational_flag) begin
      cnt_q <= 0;
      handler_ready_flag <= 1'b0;
    end else begin
      if (cnt_q < SLOW_WAIT) begin
        cnt_q <= cnt_q + 1;
      end
      handler_ready_flag <= slow ? (cnt_q >= SLOW_WAIT - 1) : 1'b1;
    end
  end
endmodule : dtsi_handler_model

// >>> verif/dtsi_top_tb.sv
// self-checking bench for the dual trunk status and indication block
`timescale 1ns/1ps

module dtsi_top_tb;
  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, irq, link_operational_flag, handler_ready_flag;
  logic [31:0] hrdata, rd;
  logic card_enable_switch = 1'b1;
  logic slow = 1'b1;
  dtsi_pkg::dtsi_line_in_type line_in = '0;
  dtsi_pkg::dtsi_ind_type ind;
  dtsi_pkg::dtsi_refclk_type ref_clk;
  dtsi_pkg::dtsi_loop_type loop_cfg;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  // line_in, link flag, near alarm, far alarm, loopback
  logic [16:0] rows [8] = '{
    {10'h001, 1'b1, 2'h0, 2'h0, 2'h0},
    {10'h102, 1'b0, 2'h1, 2'h0, 2'h0},
    {10'h043, 1'b0, 2'h1, 2'h0, 2'h0},
    {10'h010, 1'b0, 2'h0, 2'h1, 2'h0},
    {10'h201, 1'b1, 2'h2, 2'h0, 2'h0},
    {10'h022, 1'b1, 2'h0, 2'h2, 2'h0},
    {10'h007, 1'b1, 2'h0, 2'h0, 2'h1},
    {10'h003, 1'b1, 2'h0, 2'h0, 2'h0}};
  logic [31:0] ddv [3] = '{32'h081, 32'h181, 32'h381};
  logic [1:0] dde [3] = '{2'h0, 2'h2, 2'h1};

  always #4 clk_sys = ~clk_sys;

  dtsi_top dut (
    .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .card_enable_switch(card_enable_switch),
    .handler_ready_flag(handler_ready_flag), .line_in(line_in),
    .link_operational_flag(link_operational_flag), .ind(ind), .ref_clk(ref_clk),
    .loop_cfg(loop_cfg), .irq(irq));

  dtsi_handler_model hnd (
    .clk_sys(clk_sys), .resetn(resetn), .slow(slow),
    .link_operational_flag(link_operational_flag), .handler_ready_flag(handler_ready_flag));

  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task automatic end_sim;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", name, exp, got);
    end
  endtask : chk

  // single word transfer; read data taken at the edge that ends the data phase
  // a wait ends when hreadyout is high and has no limit but the bench timeout; read data is the value standing at the closing edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors = errors + 1;
      end_sim();
    end
  end

  // -----------------------------------------------------------------
  // sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    settle();
    ahb(1'b0, dtsi_pkg::DTSI_ADDR_CTRL, 32'h0);
    chk("ctrl_rst", 32'h018, rd);
    chk("net_off_rst", 32'h3, ind.net_port_off);
    chk("trunk_off_rst", 32'h3, ind.trunk_disabled);
    chk("link_rst", 32'h0, link_operational_flag);
    ahb(1'b1, dtsi_pkg::DTSI_ADDR_CTRL, 32'h081);
    ahb(1'b1, dtsi_pkg::DTSI_ADDR_LOOP, 32'h002);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      line_in <= rows[i][16:7];
      settle();
      chk("link", rows[i][6], link_operational_flag);
      chk("near", rows[i][5:4], ind.near_end_alarm);
      chk("far_tx", rows[i][5:4], ind.far_alarm_tx);
      chk("far", rows[i][3:2], ind.far_end_alarm);
      chk("loopback", rows[i][1:0], ind.remote_loopback);
      chk("inhibit", rows[i][1:0], ind.call_inhibit);
      chk("ref_clk", {2{rows[i][8:7]}}, ref_clk);
    end
    repeat (10) @(posedge clk_sys);
    ahb(1'b0, dtsi_pkg::DTSI_ADDR_STATUS, 32'h0);
    chk("status_link", 32'h18000, rd & 32'h18000);
    ahb(1'b0, dtsi_pkg::DTSI_ADDR_INT_STAT, 32'h0);
    chk("ready_event", 32'h40, rd & 32'h40);
    ahb(1'b1, dtsi_pkg::DTSI_ADDR_CTRL, 32'h001);
    settle();
    chk("link_rate", 32'h0, link_operational_flag);
    ahb(1'b1, dtsi_pkg::DTSI_ADDR_CTRL, 32'h481);
    settle();
    chk("link_port1", 32'h0, link_operational_flag);
    ahb(1'b1, dtsi_pkg::DTSI_ADDR_CTRL, 32'h0a1);
    settle();
    chk("service", 32'h1, ind.out_of_service);
    chk("link_service", 32'h0, link_operational_flag);
    ahb(1'b1, dtsi_pkg::DTSI_ADDR_CTRL, 32'h08b);
    settle();
    chk("net_off_sw", 32'h1, ind.net_port_off);
    chk("trunk_off_sw", 32'h1, ind.trunk_disabled);
    chk("link_trunk_off", 32'h0, link_operational_flag);
    // the handler now answers at once when the link comes back
    @(posedge clk_sys);
    slow <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      ahb(1'b1, dtsi_pkg::DTSI_ADDR_CTRL, ddv[j]);
      settle();
      chk("board", dde[j], {ind.board_red, ind.board_green});
    end
    ahb(1'b0, dtsi_pkg::DTSI_ADDR_STATUS, 32'h0);
    chk("status_fast", 32'h1e000, rd);
    ahb(1'b1, dtsi_pkg::DTSI_ADDR_LOOP, 32'h006);
    settle();
    chk("loop_pair", 32'h06, loop_cfg);
    ahb(1'b1, dtsi_pkg::DTSI_ADDR_LOOP, 32'h00e);
    settle();
    chk("loop_reject", 32'h06, loop_cfg);
    ahb(1'b0, dtsi_pkg::DTSI_ADDR_INT_STAT, 32'h0);
    chk("reject_event", 32'h80, rd & 32'h80);
    chk("irq_masked", 32'h0, irq);
    ahb(1'b1, dtsi_pkg::DTSI_ADDR_INT_MASK, 32'h80);
    settle();
    chk("irq_on", 32'h1, irq);
    ahb(1'b1, dtsi_pkg::DTSI_ADDR_INT_STAT, 32'hff);
    settle();
    chk("irq_clear", 32'h0, irq);
    ahb(1'b1, dtsi_pkg::DTSI_ADDR_LOOP, 32'h03f);
    settle();
    chk("ext_addr", 32'h3, ind.ext_addr);
    chk("loop_psig", 32'h3f, loop_cfg);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    @(posedge clk_sys);
    card_enable_switch <= 1'b0;
    settle();
    chk("net_off_switch", 32'h3, ind.net_port_off);
    chk("link_off", 32'h0, link_operational_flag);
    ahb(1'b1, dtsi_pkg::DTSI_ADDR_CTRL, 32'h000);
    ahb(1'b0, dtsi_pkg::DTSI_ADDR_CTRL, 32'h0);
    chk("read_off", 32'h0, rd);
    @(posedge clk_sys);
    card_enable_switch <= 1'b1;
    settle();
    ahb(1'b0, dtsi_pkg::DTSI_ADDR_CTRL, 32'h0);
    chk("ctrl_kept", 32'h381, rd);
    end_sim();
  end
endmodule : dtsi_top_tb
